// ---- verilog/timer_pkg.sv ----
// Constants shared by the dual counter/timer and its channel module
package timer_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // Internal standard clocks, period in ns, and derived cycle counts
  localparam int unsigned STD0_PERIOD_NS  = 1000;
  localparam int unsigned STD1_PERIOD_NS  = 10000;
  localparam int unsigned STD2_PERIOD_NS  = 100000;
  localparam int unsigned STD0_CYCLES     = STD0_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned STD1_CYCLES     = STD1_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned STD2_CYCLES     = STD2_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned NUM_CHAN        = 2;
  localparam int unsigned COUNT_W         = 16;
  localparam int unsigned ADDR_W          = 6;
  // Register byte offsets inside the 64-byte window
  localparam logic [5:0]  CTRL0_OFS       = 6'h00;
  localparam logic [5:0]  CTRL1_OFS       = 6'h04;
  localparam logic [5:0]  COUNT0_OFS      = 6'h08;
  localparam logic [5:0]  COUNT1_OFS      = 6'h0c;
  localparam logic [5:0]  PINS_OFS        = 6'h10;
  // Control register fields
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_GSEL_BIT   = 1;
  localparam int unsigned CTRL_CSEL_LSB   = 2;
  localparam int unsigned CTRL_MODE_LSB   = 4;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  // Clock source codes
  localparam logic [1:0]  CSEL_EXT        = 2'h0;
  // Counting modes
  localparam logic [1:0]  MODE_FREE       = 2'h0;
  localparam logic [1:0]  MODE_PERIOD     = 2'h1;
  localparam logic [1:0]  MODE_GATECNT    = 2'h2;
  localparam logic [1:0]  MODE_CLKCNT     = 2'h3;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_MAX       = 16'hffff;
  // Bus answer state
  typedef enum logic [1:0] {
    BUS_WAIT = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;
endpackage

// ---- verilog/counter_channel.sv ----
// One 16-bit counter channel with clock/gate qualification
`timescale 1ns/1ns
module counter_channel #(
  parameter bit NEG_GATE = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic [1:0]  clk_sel,
  input  wire logic [1:0]  mode,
  input  wire logic        ext_clk,
  input  wire logic        gate,
  input  wire logic [2:0]  std_tick,
  input  wire logic        clear,
  output logic      [15:0] count,
  output logic             cnt_out,
  output logic             freq_out
);
  logic        ext_prev_r;
  logic        gate_prev_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        cout_r;
  logic        cout_nxt;
  logic        fout_r;
  logic        fout_nxt;
  logic        clk_evt;
  logic        gate_act;
  logic        step;

  always_comb begin
    if (clk_sel == timer_pkg::CSEL_EXT) begin
      clk_evt = ext_clk & ~ext_prev_r;
    end else begin
      clk_evt = std_tick[clk_sel - 2'h1];
    end
    // Period mode: channel 0 counts gate high, channel 1 gate low
    gate_act = NEG_GATE ? ~gate : gate;
    case (mode)
      timer_pkg::MODE_PERIOD:  step = clk_evt & gate_act;
      timer_pkg::MODE_GATECNT: step = gate & ~gate_prev_r;
      timer_pkg::MODE_CLKCNT:  step = clk_evt;
      default:                 step = clk_evt;
    endcase
    count_nxt = count_r;
    cout_nxt  = cout_r;
    fout_nxt  = fout_r;
    if (clear) begin
      count_nxt = timer_pkg::COUNT_RESET;
    end else if (enable && step) begin
      count_nxt = count_r + 16'h0001;
      if (count_r == timer_pkg::COUNT_MAX) begin
        cout_nxt = ~cout_r;
      end
    end
    // Frequency output is the selected source halved, independent of gate
    if (enable && clk_evt) begin
      fout_nxt = ~fout_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_prev_r  <= 1'b0;
      gate_prev_r <= 1'b0;
      count_r     <= timer_pkg::COUNT_RESET;
      cout_r      <= 1'b0;
      fout_r      <= 1'b0;
    end else begin
      ext_prev_r  <= ext_clk;
      gate_prev_r <= gate;
      count_r     <= count_nxt;
      cout_r      <= cout_nxt;
      fout_r      <= fout_nxt;
    end
  end

  assign count    = count_r;
  assign cnt_out  = cout_r;
  assign freq_out = fout_r;
endmodule // counter_channel

// ---- verilog/dual_counter_timer.sv ----
// Two-channel counter/timer with an Avalon-MM register slave
// How it works
// - Register picks own or neighbouring gate source.
// - Register picks external or internal standard clock.
// - Counter 0 period mode counts gate high.
// - Counter 1 period mode counts gate low.
// - Gate-count mode counts pulses on gate input.
// - Clock-count mode counts every clock pulse.
// - Block decodes a 64-byte address window.
// - Registers sit at byte offsets from base.
`timescale 1ns/1ns
module dual_counter_timer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [1:0]  ext_clk_pin,
  input  wire logic [1:0]  gate_pin,
  output logic      [1:0]  counter_output_pin,
  output logic      [1:0]  frequency_output_pin
);
  // Bus answer: one wait cycle, then waitrequest low for one cycle
  timer_pkg::bus_state_e bus_r;
  timer_pkg::bus_state_e bus_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [7:0]  ctrl_r   [2];
  logic [7:0]  ctrl_nxt [2];
  logic [1:0]  clr_r;
  logic [1:0]  clr_nxt;
  logic [1:0]  clk_s1_r;
  logic [1:0]  clk_s2_r;
  logic [1:0]  gate_s1_r;
  logic [1:0]  gate_s2_r;
  logic [15:0] pre_r [3];
  logic [15:0] pre_nxt [3];
  logic [2:0]  tick_r;
  logic [2:0]  tick_nxt;
  logic [15:0] count [2];
  logic [1:0]  cout;
  logic [1:0]  fout;
  logic        accept;

  assign accept = (read | write) & (bus_r == timer_pkg::BUS_ACK);

  always_comb begin
    bus_nxt   = timer_pkg::BUS_WAIT;
    rdata_nxt = rdata_r;
    ctrl_nxt  = ctrl_r;
    clr_nxt   = 2'b00;
    if (bus_r == timer_pkg::BUS_WAIT && (read || write)) begin
      bus_nxt = timer_pkg::BUS_ACK;
      if (read) begin
        // Low six address bits select within the 64-byte window
        case (address)
          timer_pkg::CTRL0_OFS:  rdata_nxt = {24'h000000, ctrl_r[0]};
          timer_pkg::CTRL1_OFS:  rdata_nxt = {24'h000000, ctrl_r[1]};
          timer_pkg::COUNT0_OFS: rdata_nxt = {16'h0000, count[0]};
          timer_pkg::COUNT1_OFS: rdata_nxt = {16'h0000, count[1]};
          timer_pkg::PINS_OFS:   rdata_nxt = {24'h000000, cout, fout, gate_s2_r, clk_s2_r};
          default:               rdata_nxt = 32'h00000000;
        endcase
      end
    end
    // Writes land only on the edge that completes the transfer
    if (write && accept) begin
      case (address)
        timer_pkg::CTRL0_OFS: if (byteenable[0]) ctrl_nxt[0] = writedata[7:0];
        timer_pkg::CTRL1_OFS: if (byteenable[0]) ctrl_nxt[1] = writedata[7:0];
        timer_pkg::COUNT0_OFS: clr_nxt[0] = 1'b1;
        timer_pkg::COUNT1_OFS: clr_nxt[1] = 1'b1;
        default: clr_nxt = 2'b00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_r   <= timer_pkg::BUS_WAIT;
      rdata_r <= 32'h00000000;
      ctrl_r  <= '{timer_pkg::CTRL_RESET, timer_pkg::CTRL_RESET};
      clr_r   <= 2'b00;
    end else begin
      bus_r   <= bus_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r  <= ctrl_nxt;
      clr_r   <= clr_nxt;
    end
  end

  // Internal standard clocks: one-cycle ticks at three rates
  localparam logic [15:0] PRE_LAST [3] = '{
    16'(timer_pkg::STD0_CYCLES - 1),
    16'(timer_pkg::STD1_CYCLES - 1),
    16'(timer_pkg::STD2_CYCLES - 1)
  };

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      tick_nxt[i] = (pre_r[i] == PRE_LAST[i]);
      pre_nxt[i]  = tick_nxt[i] ? 16'h0000 : pre_r[i] + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pre_r  <= '{16'h0000, 16'h0000, 16'h0000};
      tick_r <= 3'b000;
    end else begin
      pre_r  <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge clk) begin
    if (reset) begin
      clk_s1_r  <= 2'b00;
      clk_s2_r  <= 2'b00;
      gate_s1_r <= 2'b00;
      gate_s2_r <= 2'b00;
    end else begin
      clk_s1_r  <= ext_clk_pin;
      clk_s2_r  <= clk_s1_r;
      gate_s1_r <= gate_pin;
      gate_s2_r <= gate_s1_r;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic gate_src;
      // Gate N or gate N-1; channel 0 wraps to channel 1
      assign gate_src = ctrl_r[ch][timer_pkg::CTRL_GSEL_BIT] ?
                        gate_s2_r[(ch + 1) % 2] : gate_s2_r[ch];
      counter_channel #(
        .NEG_GATE (ch == 1)
      ) u_chan (
        .clk      (clk),
        .reset    (reset),
        .enable   (ctrl_r[ch][timer_pkg::CTRL_EN_BIT]),
        .clk_sel  (ctrl_r[ch][timer_pkg::CTRL_CSEL_LSB +: 2]),
        .mode     (ctrl_r[ch][timer_pkg::CTRL_MODE_LSB +: 2]),
        .ext_clk  (clk_s2_r[ch]),
        .gate     (gate_src),
        .std_tick (tick_r),
        .clear    (clr_r[ch]),
        .count    (count[ch]),
        .cnt_out  (cout[ch]),
        .freq_out (fout[ch])
      );
    end
  endgenerate

  assign readdata             = rdata_r;
  // One-hot code: the wait bit is itself the flop, so no gate sits before the pin
  assign waitrequest          = bus_r[0];
  assign counter_output_pin   = cout;
  assign frequency_output_pin = fout;
endmodule // dual_counter_timer

// ---- bench/dual_counter_timer_props.sv ----
// Bus and reset assertions for the dual counter/timer
`timescale 1ns/1ns
module dual_counter_timer_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  counter_output_pin,
  input wire logic [1:0]  frequency_output_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic rq;
  assign rq = (read || write) && waitrequest;
  chk_one_wait:
    assert property (rq |=> !waitrequest) else $error("no answer");
  chk_ack_once:
    assert property (!waitrequest |=> waitrequest) else $error("long answer");
  chk_idle_high:
    assert property (!read && !write |=> waitrequest) else $error("idle answer");
  chk_unmapped_zero:
    assert property (rq && read && address > 6'h10 |=> readdata == 32'h0) else $error("hole");
  chk_ctrl_width:
    assert property (rq && read && address[5:3] == 3'h0 |=> readdata[31:8] == 24'h0)
      else $error("ctrl bits");
  chk_count_width:
    assert property (rq && read && address[5:3] == 3'h1 |=> readdata[31:16] == 16'h0)
      else $error("count bits");
  chk_data_hold:
    assert property (!read |=> $stable(readdata)) else $error("data moved");
  chk_reset_state:
    assert property ($fell(reset) |-> waitrequest && readdata == 32'h0
      && counter_output_pin == 2'h0 && frequency_output_pin == 2'h0) else $error("reset");
  cover property (rq && write);
  cover property (rq && read && address == timer_pkg::COUNT1_OFS);
  cover property ($changed(frequency_output_pin));
endmodule // dual_counter_timer_props
bind dual_counter_timer dual_counter_timer_props u_props (.*);

// ---- bench/sig_source.sv ----
// Signal source standing in for the wiring at the counter pins
`timescale 1ns/1ns
module sig_source (
  input wire logic   clk,
  output logic [1:0] ext_clk_pin,
  output logic [1:0] gate_pin
);
  initial ext_clk_pin = 2'h0;
  initial gate_pin = 2'h0;
  // Levels last 4 cycles so the 2-flop sync never misses one
  task automatic pulses(input logic [1:0] ch, input int k);
    repeat (k) begin
      @(posedge clk) ext_clk_pin <= ch;
      repeat (4) @(posedge clk);
      ext_clk_pin <= 2'h0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic gate(input logic [1:0] g);
    @(posedge clk) gate_pin <= g;
    repeat (4) @(posedge clk);
  endtask
endmodule // sig_source

// ---- bench/dual_counter_timer_tb_top.sv ----
// Random and directed bench for the dual counter/timer
`timescale 1ns/1ns
module dual_counter_timer_tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  ext_clk_pin;
  logic [1:0]  gate_pin;
  logic [1:0]  counter_output_pin;
  logic [1:0]  frequency_output_pin;
  logic [31:0] q;
  int          bad_count = 0;
  int          checks_done = 0;
  int          n;
  int          m;
  always #50 clk = ~clk;
  dual_counter_timer dut (.*);
  sig_source src (.*);
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %0t %h %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      bad_count++;
      wrap_up();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] md, logic [1:0] cs, logic gs);
    return {26'h0, md, cs, gs, 1'b1};
  endfunction
  // Pin status word with the external clocks idle
  function automatic logic [31:0] pins(logic [1:0] co, logic [1:0] fo, logic [1:0] g);
    return {24'h0, co, fo, g, 2'h0};
  endfunction
  initial begin
    void'($urandom(3));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(timer_pkg::CTRL0_OFS, 32'h0);
    rd(timer_pkg::COUNT0_OFS, 32'h0);
    repeat (6) begin
      n = $urandom & 32'h3e;
      bus(1'b1, timer_pkg::CTRL1_OFS, n);
      rd(timer_pkg::CTRL1_OFS, n);
      byteenable <= 4'he;
      bus(1'b1, timer_pkg::CTRL1_OFS, ~n);
      byteenable <= 4'hf;
      rd(timer_pkg::CTRL1_OFS, n);
    end
    bus(1'b1, 6'h3c, 32'hffff);
    rd(6'h3c, 32'h0);
    // Clock-count on channel 1 with the gates held at a random level
    bus(1'b1, timer_pkg::CTRL1_OFS, ctl(timer_pkg::MODE_CLKCNT, timer_pkg::CSEL_EXT, 1'b0));
    n = 1 + $urandom % 30;
    m = $urandom & 3;
    src.gate(2'(m));
    src.pulses(2'h2, n);
    repeat (4) @(posedge clk);
    rd(timer_pkg::COUNT1_OFS, n);
    rd(timer_pkg::COUNT0_OFS, 32'h0);
    rd(timer_pkg::PINS_OFS, pins(2'h0, {n[0], 1'b0}, 2'(m)));
    chk({30'h0, frequency_output_pin}, {30'h0, n[0], 1'b0});
    chk({30'h0, counter_output_pin}, 32'h0);
    // Period: channel 1 borrows channel 0's gate; its own gate is the inverse
    src.gate(2'h2);
    bus(1'b1, timer_pkg::CTRL0_OFS, ctl(timer_pkg::MODE_PERIOD, timer_pkg::CSEL_EXT, 1'b0));
    bus(1'b1, timer_pkg::CTRL1_OFS, ctl(timer_pkg::MODE_PERIOD, timer_pkg::CSEL_EXT, 1'b1));
    bus(1'b1, timer_pkg::COUNT1_OFS, 32'h0);
    n = 1 + $urandom % 30;
    m = 1 + $urandom % 30;
    src.gate(2'h1);
    src.pulses(2'h3, n);
    src.gate(2'h2);
    src.pulses(2'h3, m);
    repeat (4) @(posedge clk);
    rd(timer_pkg::COUNT0_OFS, n);
    rd(timer_pkg::COUNT1_OFS, m);
    // Gate-count: rising gate edges only
    bus(1'b1, timer_pkg::CTRL0_OFS, ctl(timer_pkg::MODE_GATECNT, timer_pkg::CSEL_EXT, 1'b0));
    bus(1'b1, timer_pkg::COUNT0_OFS, 32'h0);
    n = 1 + $urandom % 20;
    repeat (n) begin
      src.gate(2'h1);
      src.gate(2'h0);
    end
    rd(timer_pkg::COUNT0_OFS, n);
    // Internal clock: a fixed window gives a count within one tick
    bus(1'b1, timer_pkg::CTRL0_OFS, ctl(timer_pkg::MODE_FREE, 2'h1, 1'b0));
    bus(1'b1, timer_pkg::COUNT0_OFS, 32'h0);
    repeat (50 * timer_pkg::STD0_CYCLES) @(posedge clk);
    bus(1'b0, timer_pkg::COUNT0_OFS, 32'h0);
    chk({31'h0, q >= 49 && q <= 51}, 32'h1);
    wrap_up();
  end
endmodule // dual_counter_timer_tb_top
